// ==== hdl/fsr_defs.vh ====
// Constants for the flash primary status register block.
// Assumes a 40 MHz system clock; included by the design files only.
`ifndef FSR_DEFS_VH
`define FSR_DEFS_VH

// Instruction codes
`define FSR_OP_STAT_RD 8'h05
`define FSR_OP_STAT2_RD 8'h07
`define FSR_OP_REG_WR 8'h01
`define FSR_OP_WEN_SET 8'h06
`define FSR_OP_WEN_CLR 8'h04
`define FSR_OP_CLR_STAT 8'h30
`define FSR_OP_PP 8'h02
`define FSR_OP_OTPP 8'h42
`define FSR_OP_SE 8'hd8
`define FSR_OP_ALL_ERASE 8'h60
`define FSR_OP_ERASE_SUSP 8'h75
`define FSR_OP_PROG_SUSP 8'h85
`define FSR_OP_RESET 8'hf0

// Bit positions in primary_status
`define FSR_BIT_WDIS 7
`define FSR_BIT_PERR 6
`define FSR_BIT_EERR 5
`define FSR_BIT_BP_HI 4
`define FSR_BIT_BP_LO 2
`define FSR_BIT_WEN 1
`define FSR_BIT_BUSY 0

// Reset and shipped values
`define FSR_BP_VOL_RST 3'h7
`define FSR_BP_NV_SHIP 3'h0
`define FSR_WDIS_SHIP 1'h0

// Frame lengths in serial clock edges
`define FSR_CMD_BITS 6'h08
`define FSR_REGWR_BITS 6'h10
`define FSR_ADDR_BITS 6'h20

// Core operation kinds
`define FSR_KIND_PROG 2'h0
`define FSR_KIND_SERASE 2'h1
`define FSR_KIND_BERASE 2'h2

// Timing: register write duration
`define FSR_CLK_NS 25
`define FSR_REGWR_NS 1000
`define FSR_REGWR_CYC ((`FSR_REGWR_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)

`endif

// ==== hdl/fsr_sync.v ====
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to sys_clk; output is the second stage.
`timescale 1ns/1ps
module fsr_sync #(
  parameter W = 3,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire sys_clk,
  input wire nrst,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage_one;
  reg [W-1:0] stage_two;

  // First stage feeds only the second one
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge sys_clk) begin
        if (!nrst) begin
          stage_one[i] <= INIT[i];
          stage_two[i] <= INIT[i];
        end else begin
          stage_one[i] <= din[i];
          stage_two[i] <= stage_one[i];
        end
      end
    end
  endgenerate

  assign dout = stage_two;
endmodule

// ==== hdl/fsr_status_reg.v ====
// Primary status register logic of a serial NOR flash, with its command
// decoder. Assumes an SPI mode 0 host on the pins and an array engine
// on the core_* ports that answers each start with one core_done pulse.
//
// Functional notes
// R01: Volatile bits reset to defaults; non-volatile bits keep stored value (nrst reloads the shipped values instead).
// R02: 05h returns the status byte; 30h clears the error flags.
// R03: 01h writes the register, 06h sets and 04h clears write enable.
// R04: Disable bit set with protect pin low makes register write ignored.
// R05: Protect pin high or disable bit clear lets register write proceed.
// R06: Program error flag sets on failure or on a protected target.
// R07: Erase error flag sets on failure or protected sector erase.
// R08: Whole-array erase meeting a protected sector leaves erase flag clear.
// R09: Error flags are read only, cleared only by clear-status or reset.
// R10: Protection bits volatile (default ones) or non-volatile by select.
// R11: Any protection bit set refuses program and erase in its range.
// R12: Whole-array erase runs only when all protection bits are zero.
// R13: Register write, program and erase need the write-enable latch.
// R14: Set and clear commands drive the latch; register write data never sets it.
// R15: Successful program, register write or erase clears the latch.
// R16: Host clears status then write enable after a failure.
// R17: Write-enable latch is zero after any reset.
// R18: Busy bit is one while any operation runs.
// R19: While busy only status, suspend, clear-status and reset are taken.
// R20: Suspends are taken only while that array operation runs.
// R21: Flags update while busy; a set flag keeps busy until clear-status or reset.
`timescale 1ns/1ps
`include "fsr_defs.vh"
module fsr_status_reg #(
  parameter ADDR_W = 24,
  parameter REGWR_CYC = `FSR_REGWR_CYC
) (
  input wire sys_clk,
  input wire nrst,
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_si,
  input wire wp_n,
  input wire protect_volatility_select,
  input wire target_protected,
  input wire core_done,
  input wire core_fail,
  input wire core_prot_hit,
  output reg spi_so,
  output reg spi_so_oe,
  output reg core_start,
  output reg [1:0] core_op,
  output reg [ADDR_W-1:0] core_addr,
  output reg core_erase_suspend,
  output reg core_program_suspend,
  output reg [2:0] block_protect
);
  // Engine states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_REGWR = 2'b01;
  localparam [1:0] ST_CORE = 2'b10;
  localparam [1:0] ST_FAULT = 2'b11;

  // Commands that may still be taken while busy
  function busy_ok;
    input [7:0] op;
    begin
      busy_ok = (op == `FSR_OP_STAT_RD) || (op == `FSR_OP_STAT2_RD) ||
        (op == `FSR_OP_ERASE_SUSP) || (op == `FSR_OP_PROG_SUSP) ||
        (op == `FSR_OP_CLR_STAT) || (op == `FSR_OP_RESET);
    end
  endfunction

  // Commands that read a status byte back
  function is_read;
    input [7:0] op;
    begin
      is_read = (op == `FSR_OP_STAT_RD) || (op == `FSR_OP_STAT2_RD);
    end
  endfunction

  wire s_sck;
  wire s_cs_n;
  wire s_si;
  wire s_wp_n;
  reg sck_d;
  reg cs_d;
  reg [5:0] bit_cnt;
  reg [7:0] opcode;
  reg [31:0] shift;
  reg [7:0] regwr_data;
  reg [1:0] state;
  reg [1:0] kind;
  reg [15:0] regwr_cnt;
  reg wdis_nv;
  reg [2:0] bp_nv;
  reg [2:0] bp_vol;
  reg p_err;
  reg e_err;
  reg wen;
  wire [2:0] bp;
  wire busy;
  wire [7:0] status;
  wire sck_rise;
  wire sck_fall;
  wire cs_start;
  wire cs_end;
  wire [2:0] out_idx;

  // Pins cross into the system clock before any logic looks at them
  fsr_sync #(.W(4), .INIT(4'b1010)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din({wp_n, spi_sck, spi_cs_n, spi_si}),
    .dout({s_wp_n, s_sck, s_cs_n, s_si})
  );

  // Edge detection on the already synchronised copies
  always @(posedge sys_clk) begin
    if (!nrst) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sck_d <= s_sck;
      cs_d <= s_cs_n;
    end
  end

  assign sck_rise = s_sck & ~sck_d & ~s_cs_n;
  assign sck_fall = ~s_sck & sck_d & ~s_cs_n;
  assign cs_start = ~s_cs_n & cs_d;
  assign cs_end = s_cs_n & ~cs_d;
  assign out_idx = 3'h7 - bit_cnt[2:0];

  // Visible protection bits follow the volatility select
  assign bp = protect_volatility_select ? bp_vol : bp_nv; // R10
  assign busy = (state != ST_IDLE); // R18
  assign status = {wdis_nv, p_err, e_err, bp, wen, busy}; // R02

  // Serial input: opcode, then address or register data
  always @(posedge sys_clk) begin
    if (!nrst) begin
      bit_cnt <= 6'h00;
      opcode <= 8'h00;
      shift <= 32'h0;
      regwr_data <= 8'h00;
      core_addr <= {ADDR_W{1'b0}};
    end else if (cs_start) begin
      bit_cnt <= 6'h00;
    end else if (sck_rise) begin
      // Counter saturates so long data phases never wrap
      if (bit_cnt != 6'h3f)
        bit_cnt <= bit_cnt + 6'h01;
      if (bit_cnt < `FSR_CMD_BITS)
        opcode <= {opcode[6:0], s_si};
      else
        shift <= {shift[30:0], s_si};
      if (bit_cnt == `FSR_REGWR_BITS - 6'h01)
        regwr_data <= {shift[6:0], s_si};
      // Address stays put while the engine runs with it
      if (bit_cnt == `FSR_ADDR_BITS - 6'h01 && !busy)
        core_addr <= {shift[ADDR_W-2:0], s_si};
    end
  end

  // Serial output of the status byte, repeated for seven bytes, then bit 0 while chip select holds
  always @(posedge sys_clk) begin
    if (!nrst) begin
      spi_so <= 1'b0;
      spi_so_oe <= 1'b0;
    end else if (s_cs_n) begin
      spi_so <= 1'b0;
      spi_so_oe <= 1'b0;
    end else if (sck_fall && bit_cnt >= `FSR_CMD_BITS &&
                 is_read(opcode)) begin
      spi_so_oe <= 1'b1;
      // The second status register is reserved and reads as zero
      if (opcode == `FSR_OP_STAT_RD)
        spi_so <= status[out_idx]; // R02
      else
        spi_so <= 1'b0;
    end
  end

  // Protection bits handed to the range decoder outside
  always @(posedge sys_clk) begin
    if (!nrst)
      block_protect <= 3'h0;
    else
      block_protect <= bp;
  end

  // Command execution at the end of a frame, and the busy engine
  always @(posedge sys_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      kind <= `FSR_KIND_PROG;
      regwr_cnt <= 16'h0;
      wdis_nv <= `FSR_WDIS_SHIP; // R01
      bp_nv <= `FSR_BP_NV_SHIP;
      bp_vol <= `FSR_BP_VOL_RST;
      p_err <= 1'b0;
      e_err <= 1'b0;
      wen <= 1'b0; // R17
      core_start <= 1'b0;
      core_op <= `FSR_KIND_PROG;
      core_erase_suspend <= 1'b0;
      core_program_suspend <= 1'b0;
    end else begin
      core_start <= 1'b0;
      core_erase_suspend <= 1'b0;
      core_program_suspend <= 1'b0;

      // Frame decode; clears come first so a same-cycle set wins below
      if (cs_end && (!busy || busy_ok(opcode))) begin // R19
        case (opcode)
          `FSR_OP_WEN_SET: begin
            if (bit_cnt == `FSR_CMD_BITS)
              wen <= 1'b1; // R14
          end
          `FSR_OP_WEN_CLR: begin
            if (bit_cnt == `FSR_CMD_BITS)
              wen <= 1'b0; // R14
          end
          `FSR_OP_CLR_STAT: begin
            if (bit_cnt == `FSR_CMD_BITS) begin
              p_err <= 1'b0; // R09
              e_err <= 1'b0; // R09
              if (state == ST_FAULT)
                state <= ST_IDLE; // R21
            end
          end
          `FSR_OP_RESET: begin
            // Software reset restores volatile bits only
            if (bit_cnt == `FSR_CMD_BITS) begin
              p_err <= 1'b0; // R01
              e_err <= 1'b0;
              wen <= 1'b0; // R17
              bp_vol <= `FSR_BP_VOL_RST;
              state <= ST_IDLE;
            end
          end
          `FSR_OP_REG_WR: begin
            // Write-enable and the hardware lock both gate the write
            if (bit_cnt >= `FSR_REGWR_BITS && wen && // R13
                !(wdis_nv && !s_wp_n)) begin // R04 R05
              state <= ST_REGWR;
              regwr_cnt <= REGWR_CYC[15:0];
            end
          end
          `FSR_OP_PP, `FSR_OP_OTPP: begin
            if (bit_cnt >= `FSR_ADDR_BITS && wen) begin // R13
              kind <= `FSR_KIND_PROG;
              if (target_protected) begin
                state <= ST_FAULT; // R11 R21
              end else begin
                state <= ST_CORE;
                core_start <= 1'b1;
                core_op <= `FSR_KIND_PROG;
              end
            end
          end
          `FSR_OP_SE: begin
            if (bit_cnt >= `FSR_ADDR_BITS && wen) begin // R13
              kind <= `FSR_KIND_SERASE;
              if (target_protected) begin
                state <= ST_FAULT; // R11 R21
              end else begin
                state <= ST_CORE;
                core_start <= 1'b1;
                core_op <= `FSR_KIND_SERASE;
              end
            end
          end
          `FSR_OP_ALL_ERASE: begin
            // Silently dropped while any protection bit is set
            if (bit_cnt == `FSR_CMD_BITS && wen && bp == 3'h0) begin // R12
              kind <= `FSR_KIND_BERASE;
              state <= ST_CORE;
              core_start <= 1'b1;
              core_op <= `FSR_KIND_BERASE;
            end
          end
          `FSR_OP_ERASE_SUSP: begin
            if (bit_cnt == `FSR_CMD_BITS && state == ST_CORE &&
                kind != `FSR_KIND_PROG)
              core_erase_suspend <= 1'b1; // R20
          end
          `FSR_OP_PROG_SUSP: begin
            if (bit_cnt == `FSR_CMD_BITS && state == ST_CORE &&
                kind == `FSR_KIND_PROG)
              core_program_suspend <= 1'b1; // R20
          end
          default: begin
          end
        endcase
      end

      // Refused protected targets raise the matching flag at once
      if (cs_end && !busy && wen && target_protected) begin
        if ((opcode == `FSR_OP_PP || opcode == `FSR_OP_OTPP) &&
            bit_cnt >= `FSR_ADDR_BITS)
          p_err <= 1'b1; // R06
        if (opcode == `FSR_OP_SE && bit_cnt >= `FSR_ADDR_BITS)
          e_err <= 1'b1; // R07
      end

      // Register write completes after its fixed duration
      if (state == ST_REGWR) begin
        if (regwr_cnt > 16'h1) begin
          regwr_cnt <= regwr_cnt - 16'h1;
        end else begin
          wdis_nv <= regwr_data[`FSR_BIT_WDIS]; // R05
          if (protect_volatility_select)
            bp_vol <= regwr_data[`FSR_BIT_BP_HI:`FSR_BIT_BP_LO]; // R10
          else
            bp_nv <= regwr_data[`FSR_BIT_BP_HI:`FSR_BIT_BP_LO]; // R10
          wen <= 1'b0; // R15
          state <= ST_IDLE;
        end
      end

      // Array operation end: errors hold busy, success drops the latch
      if (state == ST_CORE && core_done) begin
        if (core_fail) begin
          state <= ST_FAULT; // R21
          if (kind == `FSR_KIND_PROG)
            p_err <= 1'b1; // R06
          else
            e_err <= 1'b1; // R07
        end else if (core_prot_hit && kind != `FSR_KIND_BERASE) begin
          // Whole-array erase just skips protected sectors
          state <= ST_FAULT; // R08
          if (kind == `FSR_KIND_PROG)
            p_err <= 1'b1; // R06
          else
            e_err <= 1'b1; // R07
        end else begin
          wen <= 1'b0; // R15
          state <= ST_IDLE;
        end
      end
    end
  end
endmodule

// ==== verif/fsr_status_reg_properties.sv ====
// Checker for the primary status register block, ports only.
// Assumes one sys_clk domain and a synchronous active-low nrst.
`timescale 1ns/1ps
module fsr_chk (
  input wire sys_clk,
  input wire nrst,
  input wire spi_cs_n,
  input wire spi_so_oe,
  input wire protect_volatility_select,
  input wire target_protected,
  input wire core_done,
  input wire core_start,
  input wire [1:0] core_op,
  input wire core_erase_suspend,
  input wire core_program_suspend,
  input wire [2:0] block_protect
);
  reg run;
  reg [1:0] kind;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Tracks a running array operation, so suspends can be judged
  always @(posedge sys_clk) begin
    if (!nrst) begin
      run <= 1'b0;
      kind <= 2'h0;
    end else if (core_start) begin
      run <= 1'b1;
      kind <= core_op;
    end else if (core_done) begin
      run <= 1'b0;
    end
  end
  chk_bp_reset_default: assert property ($rose(nrst) &&
    protect_volatility_select |-> ##2 block_protect == 3'h7)
    else $error("protection bits not ones after reset");
  chk_oe_release: assert property (spi_cs_n [*6] |-> !spi_so_oe)
    else $error("output enable held after deselect");
  chk_start_after_cs: assert property (
    core_start |-> spi_cs_n && $past(spi_cs_n, 3))
    else $error("start pulse before frame end");
  chk_start_pulse: assert property (core_start |=> !core_start)
    else $error("start pulse longer than one cycle");
  chk_no_prot_start: assert property (core_start && core_op != 2'h2
    |-> !$past(target_protected))
    else $error("array start on protected target");
  chk_whole_bp_zero: assert property (core_start &&
    core_op == 2'h2 |-> block_protect == 3'h0)
    else $error("whole erase with protection set");
  chk_start_not_busy: assert property (core_start |-> !run)
    else $error("start while array busy");
  chk_erase_susp_ok: assert property (core_erase_suspend |->
    run && kind != 2'h0)
    else $error("erase suspend outside erase");
  chk_prog_susp_ok: assert property (core_program_suspend |->
    run && kind == 2'h0)
    else $error("program suspend outside program");
  cov_prog: cover property (core_start && core_op == 2'h0);
  cov_whole: cover property (core_start && core_op == 2'h2);
  cov_esusp: cover property (core_erase_suspend);
  cov_psusp: cover property (core_program_suspend);
endmodule
bind fsr_status_reg fsr_chk i_chk (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .spi_cs_n(spi_cs_n),
  .spi_so_oe(spi_so_oe),
  .protect_volatility_select(protect_volatility_select),
  .target_protected(target_protected),
  .core_done(core_done),
  .core_start(core_start),
  .core_op(core_op),
  .core_erase_suspend(core_erase_suspend),
  .core_program_suspend(core_program_suspend),
  .block_protect(block_protect)
);

// ==== verif/fsr_spi_host.sv ====
// Behavioural SPI mode 0 host that frames commands to the block.
// Assumes sys_clk at 40 MHz; sck runs at 225 ns only inside frames.
`timescale 1ns/1ps
module fsr_spi_host (
  input wire sys_clk,
  input wire spi_so,
  output reg spi_sck,
  output reg spi_cs_n,
  output reg spi_si
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  // Sends n bits MSB first, returns the last 8 bits seen on spi_so
  task xfer(input [39:0] d, input integer n, output [7:0] q);
    integer i;
    begin
      q = 8'h00;
      @(posedge sys_clk) spi_cs_n <= 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge sys_clk) spi_si <= d[39-i];
        repeat (4) @(posedge sys_clk);
        spi_sck <= 1'b1;
        q = {q[6:0], spi_so};
        repeat (4) @(posedge sys_clk);
        spi_sck <= 1'b0;
      end
      // Released data line shows the inverse, never a stale value
      repeat (2) @(posedge sys_clk);
      spi_cs_n <= 1'b1;
      spi_si <= ~spi_si;
      repeat (8) @(posedge sys_clk);
    end
  endtask
endmodule

// ==== verif/flash_status_register_one_tb_top.sv ====
// Testbench for the primary status register block and its decoder.
// Assumes the host model frames all commands; engine modelled here.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmp_count = cmp_count + 1; \
  if ((a) !== (e)) begin failures = failures + 1; \
  $display("wrong value %s exp %h got %h", nm, e, a); end end
module flash_status_register_one_tb_top;
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  reg wp_n = 1'b1;
  reg vol_sel = 1'b1;
  reg tprot = 1'b0;
  reg core_done = 1'b0;
  reg fail_cfg = 1'b0;
  reg hit_cfg = 1'b0;
  reg [9:0] cnt = 10'h000;
  reg [7:0] q;
  reg [3:0] n_psusp = 4'h0;
  reg [3:0] n_esusp = 4'h0;
  integer failures = 0;
  integer cmp_count = 0;
  wire sck, cs_n, si, so, so_oe, start, esusp, psusp;
  wire [1:0] op;
  wire [23:0] addr;
  wire [2:0] bp;
  always #12.5 sys_clk = ~sys_clk;
  fsr_spi_host i_host (.sys_clk(sys_clk), .spi_so(so), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_si(si));
  fsr_status_reg #(.REGWR_CYC(4)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
    .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .wp_n(wp_n),
    .protect_volatility_select(vol_sel), .target_protected(tprot),
    .core_done(core_done), .core_fail(fail_cfg),
    .core_prot_hit(hit_cfg), .spi_so(so), .spi_so_oe(so_oe),
    .core_start(start), .core_op(op), .core_addr(addr),
    .core_erase_suspend(esusp), .core_program_suspend(psusp),
    .block_protect(bp));
  // Array engine: long enough that frames fit inside one operation
  always @(posedge sys_clk) begin
    core_done <= (cnt == 10'h001);
    if (start) cnt <= 10'h258;
    else if (cnt != 10'h000) cnt <= cnt - 10'h001;
    // Suspend pulses are counted so refused ones show up as a miss
    if (psusp) n_psusp <= n_psusp + 4'h1;
    if (esusp) n_esusp <= n_esusp + 4'h1;
  end
  task cmd(input [7:0] c);
    i_host.xfer({c, 32'h0}, 8, q);
  endtask
  task wr(input [7:0] v);
    i_host.xfer({8'h01, v, 24'h0}, 16, q);
  endtask
  task rd(input [7:0] e);
    begin
      i_host.xfer({8'h05, 32'h0}, 16, q);
      `CHK("status", e, q)
    end
  endtask
  task arr(input [7:0] c);
    i_host.xfer({c, 24'h123456, 8'h00}, 32, q);
  endtask
  task wait_done;
    integer k;
    begin
      for (k = 0; k < 900 && cnt != 10'h000; k = k + 1) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    failures = failures + 1;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(8'h1c);
    `CHK("bp port", 3'h7, bp)
    `CHK("so enable", 1'b0, so_oe)
    cmd(8'h06); rd(8'h1e);
    cmd(8'h04); rd(8'h1c);
    cmd(8'h06); cmd(8'h60); rd(8'h1e);
    wr(8'h00); rd(8'h00);
    wr(8'h9c); rd(8'h00);
    cmd(8'h06); wr(8'h80); rd(8'h80);
    wp_n <= 1'b0;
    cmd(8'h06); wr(8'h1c); rd(8'h82);
    wp_n <= 1'b1;
    wr(8'h00); rd(8'h00);
    cmd(8'h06); arr(8'h02); rd(8'h03);
    `CHK("address", 24'h123456, addr)
    cmd(8'h04); cmd(8'h85); cmd(8'h75); rd(8'h03);
    `CHK("prog suspends", 4'h1, n_psusp)
    `CHK("erase suspends", 4'h0, n_esusp)
    wait_done; rd(8'h00);
    fail_cfg <= 1'b1;
    cmd(8'h06); arr(8'h02); wait_done; rd(8'h43);
    wr(8'h00); rd(8'h43);
    cmd(8'h30); rd(8'h02); cmd(8'h04); rd(8'h00);
    cmd(8'h06); arr(8'hd8); cmd(8'h75); wait_done; rd(8'h23);
    `CHK("erase suspends", 4'h1, n_esusp)
    cmd(8'h30); cmd(8'h04); rd(8'h00);
    fail_cfg <= 1'b0;
    tprot <= 1'b1;
    cmd(8'h06); arr(8'h02); rd(8'h43);
    cmd(8'h85); cmd(8'h30); cmd(8'h04); rd(8'h00);
    `CHK("prog suspends", 4'h1, n_psusp)
    cmd(8'h06); arr(8'hd8); rd(8'h23);
    cmd(8'h30); cmd(8'h04);
    tprot <= 1'b0;
    hit_cfg <= 1'b1;
    cmd(8'h06); cmd(8'h60); wait_done; rd(8'h00);
    hit_cfg <= 1'b0;
    cmd(8'h06); cmd(8'hf0); rd(8'h1c);
    report_and_stop;
  end
endmodule
